// ---- rtl/tmc_pkg.sv ----
// package for the timer control block: register map, field positions, reset values, state struct
// assumes an 8-bit register port with one-cycle strobes and read data one cycle after the strobe
package tmc_pkg;

    localparam int ADDR_W = 8;                       // register port address width
    localparam int DATA_W = 8;                       // register port data width

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_CONTROL  = 8'hc8;   // timer_two_control
    localparam logic [ADDR_W-1:0] ADDR_RELOAD_L = 8'hca;   // reload_low_byte
    localparam logic [ADDR_W-1:0] ADDR_RELOAD_H = 8'hcb;   // reload_high_byte
    localparam logic [ADDR_W-1:0] ADDR_COUNT_L  = 8'hcc;   // count_low_byte
    localparam logic [ADDR_W-1:0] ADDR_COUNT_H  = 8'hcd;   // count_high_byte
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'he0;   // sticky interrupt status
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'he1;   // interrupt mask

    // control register field positions
    localparam int CTL_HI_OVF  = 7;                  // high_byte_overflow_flag
    localparam int CTL_LO_OVF  = 6;                  // low_byte_overflow_flag
    localparam int CTL_LO_IEN  = 5;                  // low_byte_irq_enable
    localparam int CTL_CAP_EN  = 4;                  // lfo_capture_enable
    localparam int CTL_SPLIT   = 3;                  // split_mode_select
    localparam int CTL_RUN     = 2;                  // run_control
    localparam int CTL_UNUSED  = 1;                  // reads zero, ignores writes
    localparam int CTL_EXT_CLK = 0;                  // external_clock_select

    // interrupt status / mask field positions
    localparam int IRQ_W      = 3;                   // number of interrupt events
    localparam int IRQ_HI_OVF = 0;                   // high byte overflow event
    localparam int IRQ_LO_OVF = 1;                   // low byte overflow event (when enabled)
    localparam int IRQ_CAPTUR = 2;                   // lfo capture event

    // reset values and byte constants
    localparam logic [DATA_W-1:0] CONTROL_RST = 8'h00;     // control register reset
    localparam logic [DATA_W-1:0] BYTE_ZERO   = 8'h00;     // zero byte
    localparam logic [DATA_W-1:0] BYTE_MAX    = 8'hff;     // byte rollover point
    localparam logic [DATA_W-1:0] BYTE_ONE    = 8'h01;     // increment step
    localparam logic [IRQ_W-1:0]  IRQ_ZERO    = 3'h0;      // no events
    localparam logic [DATA_W-1:0] CTL_WMASK   = 8'hfd;     // writable control bits

    // whole state of the block
    typedef struct packed {
        logic [DATA_W-1:0] control;                  // timer_two_control
        logic [DATA_W-1:0] reloadLow;                // reload_low_byte
        logic [DATA_W-1:0] reloadHigh;               // reload_high_byte
        logic [DATA_W-1:0] countLow;                 // count_low_byte
        logic [DATA_W-1:0] countHigh;                // count_high_byte
        logic [IRQ_W-1:0]  irqStatus;                // sticky interrupt events
        logic [IRQ_W-1:0]  irqMask;                  // interrupt mask
        logic              lfoPrev;                  // previous lfo level for edge detect
        logic [DATA_W-1:0] rdData;                   // read data register
        logic              irq;                      // interrupt output register
        logic              extClkSel;                // external clock select output register
    } tmc_state_s;

endpackage

// ---- rtl/tmc_timer2_ctrl.sv ----
// timer control block: 16-bit / split 8-bit auto-reload timer with overflow flags and lfo capture
// assumes ticks and the lfo level are synchronous to clk; clock source selection lives outside
// also holds the reload and count bytes, a sticky event status register and its mask
// assumes one register access per cycle and software that stops the timer before
// writing the count bytes
//
// Our own choice: the strobed register port.

// Function
// - low byte rollover from FF sets low flag
// - low flag sets in both modes
// - low flag interrupts only when enabled
// - hardware never clears the low flag
// - lfo falling edge interrupts in capture mode
// - capture copies 16-bit count into reload
// - 16-bit rollover reloads and sets high flag
// - split mode runs two 8-bit reload timers
// - split mode run bit gates high only
// - software clears both flags itself
module tmc_timer2_ctrl
    import tmc_pkg::*;
(
    input  wire logic              clk,          // system clock
    input  wire logic              arst_n,       // asynchronous reset, active low
    input  wire logic [ADDR_W-1:0] regAddr,      // register address
    input  wire logic [DATA_W-1:0] regWrData,    // register write data
    input  wire logic              regWr,        // write strobe
    input  wire logic              regRd,        // read strobe
    output logic      [DATA_W-1:0] regRdData,    // read data, valid the cycle after regRd
    input  wire logic              tickLow,      // count tick for the low byte (whole timer in 16-bit mode)
    input  wire logic              tickHigh,     // count tick for the high byte in split mode
    input  wire logic              lfoIn,        // low-frequency oscillator output
    output logic                   irq,          // level interrupt
    output logic                   extClkSel     // external clock select to the clock mux
);

    // the whole block state lives in one packed struct: one copy is the flops,
    // the other is the next value built by the combinational process below;
    // keeping them as one type means a new field cannot be forgotten in either
    tmc_state_s stQ;                             // registered state
    tmc_state_s stD;                             // next state

    // one write decode used for every register
    // a write only ever hits one address, so the decodes below never overlap;
    // the read side keeps its own case statement because it also picks data
    function automatic logic wrHit(input logic [ADDR_W-1:0] a);
        wrHit = regWr && (regAddr == a);
    endfunction

    // next-state logic
    // order matters here: software writes first, then counting, then capture,
    // then the flag merge, so that hardware events always win over software in
    // the same cycle (a flag set beats a clear, a capture beats a reload write)
    always_comb begin
        logic              split;                // split mode active
        logic              run;                  // run control
        logic              lowWrap;              // low byte rolls over this cycle
        logic              highWrap;             // high byte rolls over this cycle
        logic              lowSet;               // low flag set event
        logic              highSet;              // high flag set event
        logic              capture;              // capture event
        logic [IRQ_W-1:0]  events;               // interrupt events this cycle
        logic [DATA_W-1:0] ctlNext;              // control after software write
        split    = stQ.control[CTL_SPLIT];
        run      = stQ.control[CTL_RUN];
        lowWrap  = 1'b0;
        highWrap = 1'b0;
        lowSet   = 1'b0;
        highSet  = 1'b0;
        capture  = 1'b0;
        events   = IRQ_ZERO;
        ctlNext  = stQ.control;
        stD      = stQ;

        // software writes to counters, reload bytes and the interrupt mask
        // each write lands at the edge that takes the strobe; unmapped addresses do nothing
        if (wrHit(ADDR_RELOAD_L)) begin
            stD.reloadLow = regWrData;
        end
        if (wrHit(ADDR_RELOAD_H)) begin
            stD.reloadHigh = regWrData;
        end
        if (wrHit(ADDR_COUNT_L)) begin
            stD.countLow = regWrData;
        end
        if (wrHit(ADDR_COUNT_H)) begin
            stD.countHigh = regWrData;
        end
        if (wrHit(ADDR_IRQ_MASK)) begin
            stD.irqMask = regWrData[IRQ_W-1:0];
        end

        // counting
        // a tick that steps a count byte in the same cycle as a software write to that byte wins, since
        // counting overwrites the written value; software should stop the timer first
        if (split) begin
            // low byte runs regardless of run control
            if (tickLow) begin
                if (stQ.countLow == BYTE_MAX) begin
                    lowWrap      = 1'b1;
                    stD.countLow = stQ.reloadLow;
                end else begin
                    stD.countLow = stQ.countLow + BYTE_ONE;
                end
            end
            // high byte gated by run control
            if (run && tickHigh) begin
                if (stQ.countHigh == BYTE_MAX) begin
                    highWrap      = 1'b1;
                    stD.countHigh = stQ.reloadHigh;
                end else begin
                    stD.countHigh = stQ.countHigh + BYTE_ONE;
                end
            end
        end else if (run && tickLow) begin
            // tickHigh has no meaning in 16-bit mode and is ignored here;
            // the low byte carries into the high byte when it wraps
            // 16-bit mode: low byte wrap always flags, full wrap reloads
            if (stQ.countLow == BYTE_MAX) begin
                lowWrap = 1'b1;
                if (stQ.countHigh == BYTE_MAX) begin
                    highWrap      = 1'b1;
                    stD.countLow  = stQ.reloadLow;
                    stD.countHigh = stQ.reloadHigh;
                end else begin
                    stD.countLow  = BYTE_ZERO;
                    stD.countHigh = stQ.countHigh + BYTE_ONE;
                end
            end else begin
                stD.countLow = stQ.countLow + BYTE_ONE;
            end
        end

        // flag set events: a byte rolling over from its top value
        lowSet  = lowWrap;
        highSet = highWrap;

        // lfo falling edge capture overrides software reload writes
        // the copy takes the count as it stood before this cycle's tick, so a
        // capture and an increment in one cycle give the older value;
        // the edge detector resets low, so an lfo held high through reset is no edge
        stD.lfoPrev = lfoIn;
        if (stQ.control[CTL_CAP_EN] && stQ.lfoPrev && !lfoIn) begin
            capture        = 1'b1;
            stD.reloadLow  = stQ.countLow;
            stD.reloadHigh = stQ.countHigh;
        end

        // control register: write, then hardware set wins over clear
        // software may write 1 to a flag to set it by hand; writing 0 clears it,
        // and nothing else in the block ever clears a flag
        if (wrHit(ADDR_CONTROL)) begin
            ctlNext = regWrData & CTL_WMASK;
        end
        ctlNext[CTL_UNUSED] = 1'b0;
        ctlNext[CTL_LO_OVF] = ctlNext[CTL_LO_OVF] | lowSet;
        ctlNext[CTL_HI_OVF] = ctlNext[CTL_HI_OVF] | highSet;
        stD.control         = ctlNext;

        // interrupt events; the mask stands for the timer interrupt enable
        // the low flag only raises an event when its own enable is set; the flag
        // itself is set either way, so software must look at both flags
        events[IRQ_HI_OVF] = highSet;
        events[IRQ_LO_OVF] = lowSet && stQ.control[CTL_LO_IEN];
        events[IRQ_CAPTUR] = capture;

        // read data and read-to-clear of the status, new events win
        // the read data register is zero whenever no read was taken, so the port
        // shows a value only in the cycle after the strobe;
        // an event in the cycle of a status read stays pending for the next read
        stD.rdData = BYTE_ZERO;
        if (regRd) begin
            unique case (regAddr)
                ADDR_CONTROL:  stD.rdData = stQ.control;
                ADDR_RELOAD_L: stD.rdData = stQ.reloadLow;
                ADDR_RELOAD_H: stD.rdData = stQ.reloadHigh;
                ADDR_COUNT_L:  stD.rdData = stQ.countLow;
                ADDR_COUNT_H:  stD.rdData = stQ.countHigh;
                ADDR_IRQ_STAT: stD.rdData = {{(DATA_W-IRQ_W){1'b0}}, stQ.irqStatus};
                ADDR_IRQ_MASK: stD.rdData = {{(DATA_W-IRQ_W){1'b0}}, stQ.irqMask};
                default:       stD.rdData = BYTE_ZERO;   // unmapped reads zero
            endcase
        end
        if (regRd && (regAddr == ADDR_IRQ_STAT)) begin
            stD.irqStatus = events;
        end else begin
            stD.irqStatus = stQ.irqStatus | events;
        end

        // registered outputs
        // built from the next state so they switch on the same edge as the state
        stD.irq       = |(stD.irqStatus & stD.irqMask);
        stD.extClkSel = stD.control[CTL_EXT_CLK];
    end

    // state register
    // asynchronous reset clears everything; only constants appear in the reset branch,
    // and every field resets to zero to match the control register reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stQ <= '{control:    CONTROL_RST,
                     reloadLow:  BYTE_ZERO,
                     reloadHigh: BYTE_ZERO,
                     countLow:   BYTE_ZERO,
                     countHigh:  BYTE_ZERO,
                     irqStatus:  IRQ_ZERO,
                     irqMask:    IRQ_ZERO,
                     lfoPrev:    1'b0,
                     rdData:     BYTE_ZERO,
                     irq:        1'b0,
                     extClkSel:  1'b0};
        end else begin
            stQ <= stD;
        end
    end

    // outputs straight from flops
    // no logic sits between these flops and the pins, so the outputs
    // carry no glitches and change only just after a rising clock edge or when arst_n asserts
    assign regRdData = stQ.rdData;
    assign irq       = stQ.irq;
    assign extClkSel = stQ.extClkSel;

endmodule

// ---- verification/tmc_timer2_ctrl_asserts.sv ----
// checker for the timer control block, watching the top module's ports only
// assumes one clock domain, one-cycle register strobes and read data one cycle after the strobe
module tmc_timer2_ctrl_asserts
    import tmc_pkg::*;
(
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic              regWr,
    input wire logic              regRd,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic              tickLow,
    input wire logic              tickHigh,
    input wire logic              lfoIn,
    input wire logic              irq,
    input wire logic              extClkSel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0]       ctl_q;  // software-owned control bits
    logic [IRQ_W-1:0] mask_q; // mask shadow
    logic             lfo_q;  // previous lfo level
    logic             ctlRd_q; // read data come from control
    logic [1:0]       seen_q; // flags seen set since last control write
    // shadows follow writes; flags seen on reads are remembered
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= '0;
            mask_q <= '0;
            lfo_q <= 1'b0;
            ctlRd_q <= 1'b0;
            seen_q <= '0;
        end else begin
            lfo_q <= lfoIn;
            ctlRd_q <= regRd && regAddr == ADDR_CONTROL;
            if (regWr && regAddr == ADDR_CONTROL) ctl_q <= regWrData[5:0];
            if (regWr && regAddr == ADDR_IRQ_MASK) mask_q <= regWrData[IRQ_W-1:0];
            if (regWr && regAddr == ADDR_CONTROL) seen_q <= '0;
            else if (ctlRd_q) seen_q <= seen_q | regRdData[7:6];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ctl_mirror_a: assert property (regRd && regAddr == ADDR_CONTROL |=>
        regRdData[5:0] == {ctl_q[5:2], 1'b0, ctl_q[0]}) else $error("control read mismatch");
    flag_hold_a: assert property (ctlRd_q |-> (regRdData[7:6] & seen_q) == seen_q)
        else $error("overflow flag dropped by hardware");
    irq_mask_a: assert property (irq |-> mask_q != IRQ_ZERO) else $error("irq with mask clear");
    mask_off_a: assert property (regWr && regAddr == ADDR_IRQ_MASK && regWrData == BYTE_ZERO |=> !irq)
        else $error("irq after mask cleared");
    cap_irq_a: assert property (lfo_q && !lfoIn && ctl_q[4] && mask_q[2] && !regWr |=> irq)
        else $error("no irq on capture");
    cap_off_a: assert property (lfo_q && !lfoIn && !ctl_q[4] && !irq && !tickLow && !tickHigh
        && !regWr |=> !irq) else $error("capture irq while disabled");
    no_cause_a: assert property (!irq && !tickLow && !tickHigh && !(lfo_q && !lfoIn) && !regWr
        |=> !irq) else $error("irq without event");
    stat_clr_a: assert property (regRd && regAddr == ADDR_IRQ_STAT && !tickLow && !tickHigh
        && !(lfo_q && !lfoIn) |=> !irq) else $error("irq after status read");
endmodule
bind tmc_timer2_ctrl tmc_timer2_ctrl_asserts u_chk (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .tickLow(tickLow),
    .tickHigh(tickHigh), .lfoIn(lfoIn), .irq(irq), .extClkSel(extClkSel));

// ---- verification/tmc_timer2_ctrl_tb.sv ----
// self-checking bench for the timer control block
// assumes read data one cycle after the strobe and irq one cycle after its event
module tmc_timer2_ctrl_tb
    import tmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, tickLow = 1'b0, tickHigh = 1'b0, lfoIn = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic irq, extClkSel;
    int nFail = 0, checkCount = 0;
    always #2 clk = ~clk;
    tmc_timer2_ctrl DUT (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .tickLow(tickLow), .tickHigh(tickHigh), .lfoIn(lfoIn),
        .irq(irq), .extClkSel(extClkSel));
    task automatic endSim();
        $display("comparisons %0d, mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // compares one value and counts it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nFail++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdData, e);
        @(posedge clk);
    endtask
    // ticks for n cycles, then one idle edge so irq has landed
    task automatic tk(input logic lo, input logic hi, input int n, input logic ei);
        tickLow <= lo;
        tickHigh <= hi;
        repeat (n) @(posedge clk);
        tickLow <= 1'b0;
        tickHigh <= 1'b0;
        @(posedge clk);
        #1 chk({7'h00, irq}, {7'h00, ei});
    endtask
    // one falling edge of the lfo
    task automatic fall(input logic ei);
        lfoIn <= 1'b1;
        @(posedge clk);
        lfoIn <= 1'b0;
        tk(1'b0, 1'b0, 2, ei);
    endtask
    task automatic t_ctrl();
        rd(ADDR_CONTROL, CONTROL_RST);
        rd(8'hc9, 8'h00);
        wr(ADDR_CONTROL, 8'hff);
        rd(ADDR_CONTROL, 8'hfd);
        chk({7'h00, extClkSel}, 8'h01);
        wr(ADDR_CONTROL, 8'h00);
        $display("test control done");
    endtask
    task automatic t_wrap();
        wr(ADDR_RELOAD_L, 8'h34);
        wr(ADDR_RELOAD_H, 8'h12);
        wr(ADDR_COUNT_L, 8'hfe);
        wr(ADDR_COUNT_H, 8'hff);
        wr(ADDR_IRQ_MASK, 8'h07);
        wr(ADDR_CONTROL, 8'h04);
        tk(1'b1, 1'b0, 2, 1'b1);
        rd(ADDR_COUNT_L, 8'h34);
        rd(ADDR_COUNT_H, 8'h12);
        rd(ADDR_CONTROL, 8'hc4);
        rd(ADDR_CONTROL, 8'hc4);
        rd(ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_CONTROL, 8'h04);
        rd(ADDR_CONTROL, 8'h04);
        $display("test wrap done");
    endtask
    task automatic t_split();
        wr(ADDR_CONTROL, 8'h28);
        wr(ADDR_RELOAD_L, 8'hf0);
        wr(ADDR_RELOAD_H, 8'h55);
        wr(ADDR_COUNT_L, 8'hff);
        wr(ADDR_COUNT_H, 8'hff);
        tk(1'b1, 1'b1, 1, 1'b1);
        rd(ADDR_COUNT_L, 8'hf0);
        rd(ADDR_COUNT_H, 8'hff);
        rd(ADDR_CONTROL, 8'h68);
        rd(ADDR_IRQ_STAT, 8'h02);
        wr(ADDR_CONTROL, 8'h2c);
        tk(1'b0, 1'b1, 1, 1'b1);
        rd(ADDR_COUNT_H, 8'h55);
        rd(ADDR_CONTROL, 8'hac);
        rd(ADDR_IRQ_STAT, 8'h01);
        $display("test split done");
    endtask
    task automatic t_cap();
        wr(ADDR_CONTROL, 8'h00);
        fall(1'b0);
        wr(ADDR_COUNT_L, 8'h78);
        wr(ADDR_COUNT_H, 8'h56);
        wr(ADDR_CONTROL, 8'h10);
        fall(1'b1);
        rd(ADDR_RELOAD_L, 8'h78);
        rd(ADDR_RELOAD_H, 8'h56);
        rd(ADDR_IRQ_STAT, 8'h04);
        wr(ADDR_IRQ_MASK, 8'h00);
        $display("test capture done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_ctrl();
        t_wrap();
        t_split();
        t_cap();
        endSim();
    end
    // cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        nFail++;
        endSim();
    end
endmodule
